// ---- tb_usb_sie_status_control.sv ----
// Purpose: Self-checking bench for the engine status and control block
// Assumes: Firmware reads the status window only while the token flag is set
// Notes: Random values from a fixed xorshift seed
`timescale 1ns/100ps
module tb_usb_sie_status_control;
  logic clk = 0, reset = 1, push_rq = 0, setup_rq = 0, bt5 = 0, bt6 = 0;
  ussc_pkg::ussc_req_t req = '0;
  ussc_pkg::ussc_status_t status_in;
  logic [7:0] rdata, got, error_flags = 8'h00;
  logic [5:0] ent = 6'h00, q[$];
  logic status_push, setup_token, error_summary, tcf, allow, wake, men;
  logic [1:0] bank;
  logic [31:0] seed = 32'haefa;
  int n_mismatch = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  ussc_engine_model i_eng (.clk(clk), .push_req(push_rq), .setup_req(setup_rq), .entry(ent),
    .status_push(status_push), .status_in(status_in), .setup_token(setup_token));
  ussc_core i_dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .error_flags(error_flags), .status_push(status_push), .status_in(status_in),
    .setup_token(setup_token), .bank_toggle(bt5), .bank_toggle_ep6(bt6),
    .error_summary(error_summary), .token_complete_flag(tcf), .token_proc_allow(allow),
    .remote_wakeup_drive(wake), .module_enable(men), .bank_select(bank));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    req.wr = 1;
    req.addr = a;
    req.wdata = d;
    tick();
    req.wr = 0;
    tick();
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] g);
    req.addr = a;
    @(posedge clk);
    #1 g = rdata;
    #1;
  endtask : rd
  task automatic end_of_test;
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Scenarios
  initial begin
    repeat (12) @(posedge clk);
    #2 reset = 0;
    rd(2'h0, got);
    chk(got, 8'h00);
    rd(2'h2, got);
    chk(got, 8'h00);
    chk(tcf, 1'b0);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      if (i < 8) seed[15:0] = {8'hFF, 8'h01 << i};
      wr(2'h0, seed[7:0]);
      error_flags = seed[15:8];
      rd(2'h0, got);
      chk(got, seed[7:0] & ussc_pkg::ERR_ENABLES_MASK);
      chk(error_summary, |(seed[7:0] & seed[15:8] & 8'hBF));
    end
    wr(2'h2, 8'h05);
    chk({wake, men}, 2'h3);
    wr(2'h2, 8'h01);
    chk({wake, men}, 2'h1);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      ent = {1'b0, (seed[2:0] == 3'h7) ? 3'h6 : seed[2:0], seed[3], seed[4]};
      if (i < 4) q.push_back(ent);
      push_rq = 1;
      tick();
      push_rq = 0;
      tick();
    end
    tick();
    chk(allow, 1'b0);
    for (int i = 0; i < 4; i++) begin
      chk(tcf, 1'b1);
      rd(2'h1, got);
      chk(got, {q.pop_front(), 2'b00});
      wr(2'h3, 8'h01);
    end
    chk(tcf, 1'b0);
    setup_rq = 1;
    tick();
    setup_rq = 0;
    tick();
    chk(allow, 1'b0);
    rd(2'h2, got);
    chk(got, 8'h21);
    wr(2'h2, 8'h01);
    chk(allow, 1'b1);
    bt5 = 1;
    bt6 = 1;
    tick();
    {bt5, bt6} = 2'b00;
    chk(bank, 2'h3);
    wr(2'h2, 8'h03);
    chk(bank, 2'h0);
    rd(2'h2, got);
    chk(got, 8'h01);
    bt5 = 1;
    tick();
    bt5 = 0;
    chk(bank, 2'h1);
    wr(2'h2, 8'h00);
    chk(bank, 2'h0);
    push_rq = 1;
    tick();
    push_rq = 0;
    repeat (2) tick();
    chk(tcf, 1'b0);
    end_of_test();
  end
  initial begin
    #(25 * 3000);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_usb_sie_status_control

// ---- ussc_core.sv ----
// Purpose: CPU-facing status and control logic of a full-speed USB device engine
// Assumes: Byte register port synchronous to clk, engine events are one-cycle pulses
// Notes: Reads of the status window do not pop; clearing the token flag does
`timescale 1ns/100ps

// Summary of operation
// - Enable bits 7,5,4 gate bit-stuff, buffer and turnaround error interrupts.
// - Enable bits 3..0 gate partial-byte, CRC16, CRC5 and packet-id errors.
// - Enabled error flags are ORed into one summary error bit.
// - Each finished descriptor queues a status entry behind the visible one, unless the module is disabled or the queue is full and not popped.
// - Status queue holds four six-bit entries.
// - Clearing token-complete flag advances the window to the next entry.
// - If the next entry is valid, token-complete sets again at once.
// - Status bits 7..4 give the endpoint number, 0 to 6.
// - Status bit 3 is 1 for IN transfers, 0 for OUT.
// - Status bit 2 gives the bank: 0 even, 1 odd.
// - Setup token on an enabled module sets control bit 5 and stops packet traffic.
// - Firmware clears the hold bit; engine resumes once it reads 0.
// - Control bit 2 high drives resume signalling for remote wakeup.
// - Writing 1 to control bit 1 clears bank selectors to even.
// - Bank clear touches only endpoints 5 and 6.
// - Control bit 0 enables the module; transceiver and regulator untouched.
// - Setting module enable resets engine bank selectors.
module ussc_core (
  input wire logic clk,
  input wire logic reset,
  input wire ussc_pkg::ussc_req_t req,
  output logic [7:0] rdata,
  input wire logic [7:0] error_flags,
  input wire logic status_push,
  input wire ussc_pkg::ussc_status_t status_in,
  input wire logic setup_token,
  input wire logic bank_toggle,
  input wire logic bank_toggle_ep6,
  output logic error_summary,
  output logic token_complete_flag,
  output logic token_proc_allow,
  output logic remote_wakeup_drive,
  output logic module_enable,
  output logic [1:0] bank_select
);

  // ==========================================================
  // State
  ussc_pkg::ussc_state_t state_q;
  ussc_pkg::ussc_state_t state_d;

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = p + 2'h1;
  endfunction : ptr_inc

  // True while firmware writes the register at the given offset
  function automatic logic reg_hit(input ussc_pkg::ussc_req_t r, input logic [1:0] a);
    reg_hit = r.wr && r.addr == a;
  endfunction : reg_hit

  logic pop;
  logic push;
  logic ctl_wr;
  logic [7:0] status_byte;

  assign ctl_wr = reg_hit(req, ussc_pkg::ADDR_ENGINE_CONTROL);
  // Write 1 to clear the token flag advances the window
  assign pop = reg_hit(req, ussc_pkg::ADDR_TOKEN_FLAGS)
    && req.wdata[ussc_pkg::FLAG_TOKEN] && state_q.token_flag;
  assign push = status_push && state_q.enable
    && (state_q.count < 3'(ussc_pkg::FIFO_DEPTH) || pop);
  assign status_byte = {state_q.fifo[state_q.rd_ptr].endpoint_number,
    state_q.fifo[state_q.rd_ptr].in_transfer,
    state_q.fifo[state_q.rd_ptr].odd_bank, 2'b00};

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    if (reg_hit(req, ussc_pkg::ADDR_ERR_ENABLES)) begin
      state_d.err_en = req.wdata & ussc_pkg::ERR_ENABLES_MASK;
    end
    if (ctl_wr) begin
      state_d.hold = req.wdata[ussc_pkg::CTL_HOLD];
      state_d.wakeup = req.wdata[ussc_pkg::CTL_WAKEUP];
      state_d.enable = req.wdata[ussc_pkg::CTL_ENABLE];
      if (req.wdata[ussc_pkg::CTL_ENABLE] && !state_q.enable) begin
        state_d.bank_sel = ussc_pkg::BANK_SELECT_RESET;
      end
    end
    if (bank_toggle) begin
      state_d.bank_sel[0] = ~state_q.bank_sel[0];
    end
    if (bank_toggle_ep6) begin
      state_d.bank_sel[1] = ~state_q.bank_sel[1];
    end
    if (ctl_wr && req.wdata[ussc_pkg::CTL_BANK_CLEAR]) begin
      state_d.bank_sel = ussc_pkg::BANK_SELECT_RESET;
    end
    // Setup token wins over a simultaneous firmware clear
    if (setup_token && state_q.enable) begin
      state_d.hold = 1'b1;
    end
    if (pop) begin
      state_d.rd_ptr = ptr_inc(state_q.rd_ptr);
    end
    if (push) begin
      state_d.fifo[state_q.wr_ptr] = status_in;
      state_d.wr_ptr = ptr_inc(state_q.wr_ptr);
    end
    state_d.count = state_q.count + 3'(push) - 3'(pop);
    // Flag reflects a valid visible entry, so it reasserts after a pop
    state_d.token_flag = state_d.count != 3'h0;
    unique case (req.addr)
      ussc_pkg::ADDR_ERR_ENABLES: state_d.rdata = state_q.err_en;
      ussc_pkg::ADDR_STATUS_WINDOW: state_d.rdata = status_byte;
      ussc_pkg::ADDR_ENGINE_CONTROL: state_d.rdata = {2'b00, state_q.hold, 2'b00,
        state_q.wakeup, 1'b0, state_q.enable};
      ussc_pkg::ADDR_TOKEN_FLAGS: state_d.rdata = {7'h00, state_q.token_flag};
    endcase
    if (!state_q.enable) begin
      state_d.bank_sel = ussc_pkg::BANK_SELECT_RESET;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = state_q.rdata;
  assign error_summary = |(error_flags & state_q.err_en);
  assign token_complete_flag = state_q.token_flag;
  assign token_proc_allow = state_q.enable && !state_q.hold
    && state_q.count < 3'(ussc_pkg::FIFO_DEPTH);
  assign remote_wakeup_drive = state_q.wakeup;
  assign module_enable = state_q.enable;
  assign bank_select = state_q.bank_sel;

  // ==========================================================
  // Checks
  sequence seq_clear_token;
    pop && state_q.count > 3'h1 && !push;
  endsequence

  AST_ERR_GATE: assert property (@(posedge clk) disable iff (reset)
    error_summary == |(error_flags & state_q.err_en & ussc_pkg::ERR_ENABLES_MASK))
    else $error("summary error mismatch");
  AST_ERR_BIT6: assert property (@(posedge clk) disable iff (reset)
    !state_q.err_en[6]) else $error("reserved enable set");
  AST_ERR_EN_WR: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.addr == ussc_pkg::ADDR_ERR_ENABLES |=> state_q.err_en[0] == $past(req.wdata[0]))
    else $error("enable write lost");
  AST_REASSERT: assert property (@(posedge clk) disable iff (reset)
    seq_clear_token |=> token_complete_flag) else $error("token flag not reasserted");
  AST_ADVANCE: assert property (@(posedge clk) disable iff (reset)
    pop |=> state_q.rd_ptr == $past(state_q.rd_ptr) + 2'h1) else $error("window not advanced");
  AST_DEPTH: assert property (@(posedge clk) disable iff (reset)
    state_q.count <= 3'h4) else $error("queue overfilled");
  AST_FULL_HOLD: assert property (@(posedge clk) disable iff (reset)
    state_q.count == 3'h4 |-> !token_proc_allow) else $error("full queue not held");
  AST_SETUP_HOLD: assert property (@(posedge clk) disable iff (reset)
    setup_token && module_enable |=> !token_proc_allow [*1]) else $error("setup did not hold");
  AST_BANK_CLR: assert property (@(posedge clk) disable iff (reset)
    ctl_wr && req.wdata[ussc_pkg::CTL_BANK_CLEAR] |=> bank_select == 2'h0)
    else $error("bank not cleared");
  AST_FLAG_EMPTY: assert property (@(posedge clk) disable iff (reset)
    token_complete_flag == (state_q.count != 3'h0)) else $error("flag without entry");

  // ==========================================================
  // Sequences for multi-step checks
  sequence seq_window_read;
    req.addr == ussc_pkg::ADDR_STATUS_WINDOW;
  endsequence

  sequence seq_control_read;
    req.addr == ussc_pkg::ADDR_ENGINE_CONTROL;
  endsequence

  sequence seq_setup_seen;
    setup_token && module_enable;
  endsequence

  sequence seq_hold_release;
    ctl_wr && !req.wdata[ussc_pkg::CTL_HOLD] && !(setup_token && module_enable);
  endsequence

  sequence seq_enable_rise;
    ctl_wr && req.wdata[ussc_pkg::CTL_ENABLE] && !module_enable;
  endsequence

  sequence seq_refused_push;
    status_push && !pop && (!module_enable || state_q.count == 3'h4);
  endsequence

  // ==========================================================
  // Error enables and summary
  AST_GATE_BTS: assert property (@(posedge clk) disable iff (reset)
    error_flags[ussc_pkg::ERR_BIT_STUFF] && state_q.err_en[ussc_pkg::ERR_BIT_STUFF]
    |-> error_summary) else $error("bit-stuff error not raised");
  AST_GATE_BUF: assert property (@(posedge clk) disable iff (reset)
    error_flags[ussc_pkg::ERR_BUFFER] && state_q.err_en[ussc_pkg::ERR_BUFFER]
    |-> error_summary) else $error("buffer error not raised");
  AST_GATE_BTO: assert property (@(posedge clk) disable iff (reset)
    error_flags[ussc_pkg::ERR_TURNAROUND] && state_q.err_en[ussc_pkg::ERR_TURNAROUND]
    |-> error_summary) else $error("turnaround error not raised");
  AST_GATE_DFN: assert property (@(posedge clk) disable iff (reset)
    error_flags[ussc_pkg::ERR_PARTIAL_BYTE] && state_q.err_en[ussc_pkg::ERR_PARTIAL_BYTE]
    |-> error_summary) else $error("partial byte error not raised");
  AST_GATE_CRC16: assert property (@(posedge clk) disable iff (reset)
    error_flags[ussc_pkg::ERR_CRC16] && state_q.err_en[ussc_pkg::ERR_CRC16]
    |-> error_summary) else $error("crc16 error not raised");
  AST_GATE_CRC5: assert property (@(posedge clk) disable iff (reset)
    error_flags[ussc_pkg::ERR_CRC5] && state_q.err_en[ussc_pkg::ERR_CRC5]
    |-> error_summary) else $error("crc5 error not raised");
  AST_GATE_PID: assert property (@(posedge clk) disable iff (reset)
    error_flags[ussc_pkg::ERR_PACKET_ID] && state_q.err_en[ussc_pkg::ERR_PACKET_ID]
    |-> error_summary) else $error("packet id error not raised");
  AST_GATE_NONE: assert property (@(posedge clk) disable iff (reset)
    (error_flags & state_q.err_en) == 8'h00 |-> !error_summary)
    else $error("summary without enabled flag");
  AST_FLAGS_QUIET: assert property (@(posedge clk) disable iff (reset)
    error_flags == 8'h00 |-> !error_summary)
    else $error("summary without any flag");
  AST_BIT6_IGNORED: assert property (@(posedge clk) disable iff (reset)
    error_flags == 8'h40 |-> !error_summary)
    else $error("unused flag raised summary");
  AST_ERR_EN_MASKED: assert property (@(posedge clk) disable iff (reset)
    reg_hit(req, ussc_pkg::ADDR_ERR_ENABLES) |=> state_q.err_en == ($past(req.wdata) & 8'hBF))
    else $error("enable write not stored");
  AST_ERR_EN_KEEP: assert property (@(posedge clk) disable iff (reset)
    !reg_hit(req, ussc_pkg::ADDR_ERR_ENABLES) |=> state_q.err_en == $past(state_q.err_en))
    else $error("enables changed without write");
  AST_ERR_READ: assert property (@(posedge clk) disable iff (reset)
    req.addr == ussc_pkg::ADDR_ERR_ENABLES |=> rdata == $past(state_q.err_en))
    else $error("enable read wrong");

  // ==========================================================
  // Status queue
  AST_PUSH_COUNT: assert property (@(posedge clk) disable iff (reset)
    push && !pop |=> state_q.count == $past(state_q.count) + 3'h1)
    else $error("push not counted");
  AST_POP_COUNT: assert property (@(posedge clk) disable iff (reset)
    pop && !push |=> state_q.count == $past(state_q.count) - 3'h1)
    else $error("pop not counted");
  AST_PUSH_POP: assert property (@(posedge clk) disable iff (reset)
    push && pop |=> state_q.count == $past(state_q.count))
    else $error("push with pop changed count");
  AST_PUSH_STORE: assert property (@(posedge clk) disable iff (reset)
    push |=> state_q.fifo[$past(state_q.wr_ptr)] == $past(status_in))
    else $error("entry not stored");
  AST_PUSH_FLAG: assert property (@(posedge clk) disable iff (reset)
    push |=> token_complete_flag)
    else $error("flag not set by entry");
  AST_REFUSED: assert property (@(posedge clk) disable iff (reset)
    seq_refused_push |=> state_q.count == $past(state_q.count))
    else $error("refused entry stored");
  AST_POP_FLAG: assert property (@(posedge clk) disable iff (reset)
    pop |-> token_complete_flag)
    else $error("pop without visible entry");
  AST_RD_PTR_KEEP: assert property (@(posedge clk) disable iff (reset)
    !pop |=> state_q.rd_ptr == $past(state_q.rd_ptr))
    else $error("window moved without clear");
  AST_WR_PTR_ADV: assert property (@(posedge clk) disable iff (reset)
    push |=> state_q.wr_ptr == $past(state_q.wr_ptr) + 2'h1)
    else $error("write slot not advanced");
  AST_WR_PTR_KEEP: assert property (@(posedge clk) disable iff (reset)
    !push |=> state_q.wr_ptr == $past(state_q.wr_ptr))
    else $error("write slot moved");
  AST_PTR_GAP: assert property (@(posedge clk) disable iff (reset)
    state_q.wr_ptr - state_q.rd_ptr == state_q.count[1:0])
    else $error("slot gap differs from count");
  AST_FLAG_KEEP: assert property (@(posedge clk) disable iff (reset)
    !push && !pop |=> token_complete_flag == $past(token_complete_flag))
    else $error("flag changed on its own");

  // ==========================================================
  // Status window reads
  AST_WIN_ENDPOINT: assert property (@(posedge clk) disable iff (reset)
    seq_window_read |=> rdata[7:4] == $past(state_q.fifo[state_q.rd_ptr].endpoint_number))
    else $error("endpoint field wrong");
  AST_WIN_IN: assert property (@(posedge clk) disable iff (reset)
    seq_window_read |=> rdata[3] == $past(state_q.fifo[state_q.rd_ptr].in_transfer))
    else $error("direction field wrong");
  AST_WIN_ODD: assert property (@(posedge clk) disable iff (reset)
    seq_window_read |=> rdata[2] == $past(state_q.fifo[state_q.rd_ptr].odd_bank))
    else $error("bank field wrong");
  AST_WIN_LOW: assert property (@(posedge clk) disable iff (reset)
    seq_window_read |=> rdata[1:0] == 2'b00)
    else $error("unused status bits set");
  AST_FLAG_READ: assert property (@(posedge clk) disable iff (reset)
    req.addr == ussc_pkg::ADDR_TOKEN_FLAGS |=> rdata == {7'h00, $past(token_complete_flag)})
    else $error("flag read wrong");

  // ==========================================================
  // Engine control
  AST_HOLD_SET: assert property (@(posedge clk) disable iff (reset)
    seq_setup_seen |=> state_q.hold)
    else $error("setup did not set hold");
  AST_HOLD_KEEP: assert property (@(posedge clk) disable iff (reset)
    state_q.hold && !(ctl_wr && !req.wdata[ussc_pkg::CTL_HOLD]) |=> state_q.hold)
    else $error("hold dropped without clear");
  AST_HOLD_CLEAR: assert property (@(posedge clk) disable iff (reset)
    seq_hold_release |=> !state_q.hold)
    else $error("hold not cleared");
  AST_ALLOW_BACK: assert property (@(posedge clk) disable iff (reset)
    module_enable && !state_q.hold && state_q.count < 3'h4 |-> token_proc_allow)
    else $error("tokens not resumed");
  AST_DISABLED_BLOCK: assert property (@(posedge clk) disable iff (reset)
    !module_enable |-> !token_proc_allow)
    else $error("tokens while disabled");
  AST_WAKE_FOLLOW: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |=> remote_wakeup_drive == $past(req.wdata[ussc_pkg::CTL_WAKEUP]))
    else $error("wakeup not taken");
  AST_WAKE_KEEP: assert property (@(posedge clk) disable iff (reset)
    !ctl_wr |=> remote_wakeup_drive == $past(remote_wakeup_drive))
    else $error("wakeup ended by hardware");
  AST_ENABLE_FOLLOW: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |=> module_enable == $past(req.wdata[ussc_pkg::CTL_ENABLE]))
    else $error("enable not taken");
  AST_ENABLE_BANK: assert property (@(posedge clk) disable iff (reset)
    seq_enable_rise |=> bank_select == 2'h0)
    else $error("enable did not reset banks");
  AST_DISABLED_BANK: assert property (@(posedge clk) disable iff (reset)
    !module_enable |=> bank_select == 2'h0)
    else $error("banks kept while disabled");
  AST_TOGGLE_EP5: assert property (@(posedge clk) disable iff (reset)
    bank_toggle && module_enable && !ctl_wr |=> bank_select[0] != $past(bank_select[0]))
    else $error("endpoint 5 bank not toggled");
  AST_TOGGLE_EP6: assert property (@(posedge clk) disable iff (reset)
    bank_toggle_ep6 && module_enable && !ctl_wr |=> bank_select[1] != $past(bank_select[1]))
    else $error("endpoint 6 bank not toggled");
  AST_CTL_READ: assert property (@(posedge clk) disable iff (reset)
    seq_control_read |=> rdata[ussc_pkg::CTL_HOLD] == $past(state_q.hold))
    else $error("hold read wrong");
  AST_CTL_READ_BITS: assert property (@(posedge clk) disable iff (reset)
    seq_control_read |=> rdata[ussc_pkg::CTL_BANK_CLEAR] == 1'b0)
    else $error("bank clear bit reads back");

endmodule : ussc_core

// ---- ussc_engine_model.sv ----
// Purpose: Behavioural packet engine beside the status and control block
// Assumes: Requests from the bench arrive just after a rising edge
// Notes: Status lines carry the inverted entry bits whenever no entry is offered
`timescale 1ns/100ps
module ussc_engine_model (
  input wire logic clk,
  input wire logic push_req,
  input wire logic setup_req,
  input wire logic [5:0] entry,
  output logic status_push,
  output ussc_pkg::ussc_status_t status_in,
  output logic setup_token
);
  // ==========================================================
  // One pulse per finished descriptor or setup token
  always_ff @(posedge clk) begin
    status_push <= push_req;
    status_in <= push_req ? entry : ~entry;
    setup_token <= setup_req;
  end
endmodule : ussc_engine_model

// ---- ussc_pkg.sv ----
// Purpose: Shared constants and types for the USB engine status and control block
// Assumes: Byte-wide register port, offsets chosen locally
// Notes: Error enables, status FIFO window and engine control bits
package ussc_pkg;

  // ==========================================================
  // Register map
  localparam logic [1:0] ADDR_ERR_ENABLES = 2'h0;
  localparam logic [1:0] ADDR_STATUS_WINDOW = 2'h1;
  localparam logic [1:0] ADDR_ENGINE_CONTROL = 2'h2;
  localparam logic [1:0] ADDR_TOKEN_FLAGS = 2'h3;

  // ==========================================================
  // Field positions
  localparam int ERR_BIT_STUFF = 7;
  localparam int ERR_BUFFER = 5;
  localparam int ERR_TURNAROUND = 4;
  localparam int ERR_PARTIAL_BYTE = 3;
  localparam int ERR_CRC16 = 2;
  localparam int ERR_CRC5 = 1;
  localparam int ERR_PACKET_ID = 0;
  localparam int CTL_HOLD = 5;
  localparam int CTL_WAKEUP = 2;
  localparam int CTL_BANK_CLEAR = 1;
  localparam int CTL_ENABLE = 0;
  localparam int FLAG_TOKEN = 0;

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] ERR_ENABLES_RESET = 8'h00;
  localparam logic [7:0] ERR_ENABLES_MASK = 8'hBF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'h27;
  localparam int FIFO_DEPTH = 4;
  localparam int NUM_ENDPOINTS = 7;
  localparam logic [1:0] BANK_SELECT_RESET = 2'h0;

  // One status entry from the packet engine
  typedef struct packed {
    logic [3:0] endpoint_number;
    logic in_transfer;
    logic odd_bank;
  } ussc_status_t;

  // Register write/read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } ussc_req_t;

  typedef struct packed {
    logic [7:0] err_en;
    logic hold;
    logic wakeup;
    logic enable;
    logic [1:0] bank_sel;
    logic [1:0] rd_ptr;
    logic [1:0] wr_ptr;
    logic [2:0] count;
    logic token_flag;
    logic [7:0] rdata;
    ussc_status_t [FIFO_DEPTH-1:0] fifo;
  } ussc_state_t;

endpackage : ussc_pkg
